// ===== core/snvm_pkg.sv
// constants, types and op-codes shared by the serial nonvolatile memory slave
package snvm_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 8192;
  localparam int ADDR_HI_BITS = 5;
  localparam logic [12:0] ADDR_STEP = 13'h0001;

  // ----------------------------------------------------------------
  // op-codes, first byte of every selection
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_MEM_READ = 8'h03;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;

  // ----------------------------------------------------------------
  // bit counting within a byte, msb first
  // ----------------------------------------------------------------
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;

  // ----------------------------------------------------------------
  // block protection codes and range bases
  // ----------------------------------------------------------------
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam logic [12:0] PROT_QUARTER_BASE = 13'h1800;
  localparam logic [12:0] PROT_HALF_BASE = 13'h1000;

  // ----------------------------------------------------------------
  // status byte layout: bit 7 pen, 3..2 block protect, 1 latch
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pin_protect_enable;
    logic [2:0] zero_hi;
    logic block_protect_hi;
    logic block_protect_lo;
    logic write_latch_flag;
    logic zero_lo;
  } snvm_status_t;

  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // phases of one selection
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_ADDR_HI,
    PH_ADDR_LO,
    PH_MEM_READ,
    PH_MEM_WRITE,
    PH_STATUS_READ,
    PH_STATUS_WRITE,
    PH_DONE
  } snvm_phase_t;

endpackage

// ===== core/snvm_core.sv
// spi slave command engine and storage of the serial nonvolatile memory
//
// How it works
// - mode latched at select fall from clock level; modes 0 and 3 work.
// - first bit sampled on first rising clock after select falls.
// - first byte is op-code; one op-code per selection.
// - bytes msb first, inputs on rising edges, outputs on falling edges.
// - 06h sets write latch, 04h clears it, no further bytes.
// - 05h returns status byte, 01h takes one status byte.
// - 03h reads memory, 02h writes memory, both take address and data.
// - latch clear at power-up; writes need it; completing a write clears it.
// - latch-clear command refuses writes; latch shows in status bit 1.
// - status read shifts out exactly one byte of current status.
// - status: pen bit 7, protect bits 3..2, latch bit 1, rest zero.
// - pen and block-protect bits persist like nonvolatile storage.
// - protect code selects none, upper quarter, upper half or whole array.
// - status write blocked when pen set and protect pin low.
// - two address bytes follow; top 3 bits ignored, 13 bits used.
// - address increments per byte and wraps from last to zero.
// - each write byte committed at its 8th clock; unlimited burst.
// - read ignores input after address; one bit per clock until deselect.
// - hold low pauses the operation; clocks during hold are ignored.
// - select high: output off, inputs ignored, standby.
// - output driven only while read data returns, never during hold.
`timescale 1ns/10ps

module snvm_core #(
  parameter int ADDR_W = snvm_pkg::ADDR_W,
  parameter int DATA_W = snvm_pkg::DATA_W,
  parameter int MEM_DEPTH = snvm_pkg::MEM_DEPTH
) (
  // system side
  input wire logic clk,
  input wire logic rst,
  // spi pins, link clock domain
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so_o,
  output logic so_oe,
  // observation in the system clock domain
  output logic sys_selected,
  output logic sys_write_latch,
  output logic sys_mode3,
  output logic sys_commit_pulse
);

  // ----------------------------------------------------------------
  // link-domain reset
  // ----------------------------------------------------------------
  // assert at once, release on sck so no link flop sees a runt release
  logic rst_link_a_r;
  logic rst_link_r;

  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      rst_link_a_r <= 1'b1;
      rst_link_r <= 1'b1;
    end else begin
      rst_link_a_r <= 1'b0;
      rst_link_r <= rst_link_a_r;
    end
  end

  // ----------------------------------------------------------------
  // per-selection state, cleared while select is high except mode3_r
  // ----------------------------------------------------------------
  snvm_pkg::snvm_phase_t phase_r;
  logic [2:0] bit_cnt_r;
  logic [DATA_W-2:0] shift_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] tx_byte_r;
  logic tx_act_r;
  logic wr_grant_r;
  logic mode3_r;

  // ----------------------------------------------------------------
  // persistent state
  // ----------------------------------------------------------------
  logic write_latch_r;
  logic pin_protect_enable_r;
  logic [1:0] block_protect_r;
  logic [DATA_W-1:0] mem_r [MEM_DEPTH];
  logic commit_tog_r;

  // ----------------------------------------------------------------
  // byte assembly and decode
  // ----------------------------------------------------------------
  logic byte_done;
  logic [DATA_W-1:0] rx_byte;
  logic active;
  logic addr_protected;
  logic mem_we;
  logic status_we;
  logic status_locked;
  logic [ADDR_W-1:0] addr_inc;
  snvm_pkg::snvm_status_t status_view;
  snvm_pkg::snvm_status_t status_in;
  logic [1:0] wp_sync_r;

  // clocks only count while selected and not on hold
  assign active = ~cs_n & hold_n;
  assign byte_done = (bit_cnt_r == snvm_pkg::BIT_LAST);
  assign rx_byte = {shift_r, si};
  assign status_in = rx_byte;
  assign addr_inc = addr_r + snvm_pkg::ADDR_STEP;

  always_comb begin
    unique case (block_protect_r)
      snvm_pkg::BP_NONE: addr_protected = 1'b0;
      snvm_pkg::BP_QUARTER: addr_protected = (addr_r >= snvm_pkg::PROT_QUARTER_BASE);
      snvm_pkg::BP_HALF: addr_protected = (addr_r >= snvm_pkg::PROT_HALF_BASE);
      snvm_pkg::BP_ALL: addr_protected = 1'b1;
    endcase
  end

  // protect pin is asynchronous to sck; two flops before use
  always_ff @(posedge sck) begin
    wp_sync_r <= {wp_sync_r[0], wp_n};
  end

  // the pin is honoured only when pen is set
  assign status_locked = pin_protect_enable_r & ~wp_sync_r[1];

  // refused bytes still walk the address
  assign mem_we = active & byte_done & (phase_r == snvm_pkg::PH_MEM_WRITE)
                  & wr_grant_r & ~addr_protected;

  assign status_we = active & byte_done & (phase_r == snvm_pkg::PH_STATUS_WRITE)
                     & write_latch_r & ~status_locked;

  always_comb begin
    status_view = snvm_pkg::STATUS_RESET;
    status_view.pin_protect_enable = pin_protect_enable_r;
    status_view.block_protect_hi = block_protect_r[1];
    status_view.block_protect_lo = block_protect_r[0];
    status_view.write_latch_flag = write_latch_r;
  end

  // ----------------------------------------------------------------
  // mode capture at select fall
  // ----------------------------------------------------------------
  // clock high at select fall means mode 3; both run the same edges
  always_ff @(negedge cs_n or posedge rst_link_r) begin
    if (rst_link_r) begin
      mode3_r <= 1'b0;
    end else begin
      mode3_r <= sck;
    end
  end

  // ----------------------------------------------------------------
  // bit counter and input shift, rising edge
  // ----------------------------------------------------------------
  // select high acts as reset, so each selection restarts at bit 0
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_r <= snvm_pkg::BIT_FIRST;
      shift_r <= '0;
    end else if (hold_n) begin
      bit_cnt_r <= bit_cnt_r + snvm_pkg::BIT_STEP;
      shift_r <= rx_byte[DATA_W-2:0];
    end
  end

  // ----------------------------------------------------------------
  // command phase machine, rising edge
  // ----------------------------------------------------------------
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      phase_r <= snvm_pkg::PH_OPCODE;
      wr_grant_r <= 1'b0;
    end else if (hold_n && byte_done) begin
      unique case (phase_r)
        snvm_pkg::PH_OPCODE: begin
          unique case (rx_byte)
            snvm_pkg::OP_STATUS_READ: phase_r <= snvm_pkg::PH_STATUS_READ;
            snvm_pkg::OP_STATUS_WRITE: phase_r <= snvm_pkg::PH_STATUS_WRITE;
            snvm_pkg::OP_MEM_READ: phase_r <= snvm_pkg::PH_ADDR_HI;
            snvm_pkg::OP_MEM_WRITE: phase_r <= snvm_pkg::PH_ADDR_HI;
            default: phase_r <= snvm_pkg::PH_DONE;
          endcase
        end
        snvm_pkg::PH_ADDR_HI: begin
          phase_r <= snvm_pkg::PH_ADDR_LO;
        end
        snvm_pkg::PH_ADDR_LO: begin
          if (tx_act_r) begin
            phase_r <= snvm_pkg::PH_MEM_READ;
          end else begin
            phase_r <= snvm_pkg::PH_MEM_WRITE;
            // latch state at burst start governs the whole burst
            wr_grant_r <= write_latch_r;
          end
        end
        snvm_pkg::PH_MEM_READ: phase_r <= snvm_pkg::PH_MEM_READ;
        snvm_pkg::PH_MEM_WRITE: phase_r <= snvm_pkg::PH_MEM_WRITE;
        snvm_pkg::PH_STATUS_READ: phase_r <= snvm_pkg::PH_DONE;
        snvm_pkg::PH_STATUS_WRITE: phase_r <= snvm_pkg::PH_DONE;
        snvm_pkg::PH_DONE: phase_r <= snvm_pkg::PH_DONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // address counter, rising edge
  // ----------------------------------------------------------------
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      addr_r <= '0;
    end else if (hold_n && byte_done) begin
      if (phase_r == snvm_pkg::PH_ADDR_HI) begin
        addr_r[ADDR_W-1:DATA_W] <= rx_byte[snvm_pkg::ADDR_HI_BITS-1:0];
      end else if (phase_r == snvm_pkg::PH_ADDR_LO) begin
        addr_r[DATA_W-1:0] <= rx_byte;
      end else if (phase_r == snvm_pkg::PH_MEM_READ || phase_r == snvm_pkg::PH_MEM_WRITE) begin
        addr_r <= addr_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // outgoing byte and read flag, rising edge
  // ----------------------------------------------------------------
  // tx_act_r also marks a read op-code while the address is shifting
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      tx_byte_r <= '0;
      tx_act_r <= 1'b0;
    end else if (hold_n && byte_done) begin
      unique case (phase_r)
        snvm_pkg::PH_OPCODE: begin
          tx_byte_r <= status_view;
          tx_act_r <= (rx_byte == snvm_pkg::OP_STATUS_READ)
                      | (rx_byte == snvm_pkg::OP_MEM_READ);
        end
        snvm_pkg::PH_ADDR_LO: begin
          tx_byte_r <= mem_r[{addr_r[ADDR_W-1:DATA_W], rx_byte}];
        end
        snvm_pkg::PH_MEM_READ: begin
          tx_byte_r <= mem_r[addr_inc];
        end
        snvm_pkg::PH_STATUS_READ: begin
          tx_act_r <= 1'b0;
        end
        default: begin
          tx_byte_r <= tx_byte_r;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // serial output, falling edge
  // ----------------------------------------------------------------
  logic so_r;
  logic drive_r;
  logic read_out;

  // address phases keep tx_act_r high but must not drive yet
  assign read_out = tx_act_r & (phase_r != snvm_pkg::PH_ADDR_HI)
                    & (phase_r != snvm_pkg::PH_ADDR_LO);

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_r <= 1'b0;
      drive_r <= 1'b0;
    end else if (hold_n) begin
      drive_r <= read_out;
      so_r <= tx_byte_r[snvm_pkg::BIT_LAST - bit_cnt_r];
    end
  end

  assign so_o = so_r;
  assign so_oe = ~cs_n & hold_n & drive_r;

  // ----------------------------------------------------------------
  // write latch
  // ----------------------------------------------------------------
  always_ff @(posedge sck or posedge rst_link_r) begin
    if (rst_link_r) begin
      write_latch_r <= 1'b0;
    end else if (active && byte_done) begin
      if (phase_r == snvm_pkg::PH_OPCODE && rx_byte == snvm_pkg::OP_SET_WRITE_LATCH) begin
        write_latch_r <= 1'b1;
      end else if (phase_r == snvm_pkg::PH_OPCODE
                   && rx_byte == snvm_pkg::OP_CLEAR_WRITE_LATCH) begin
        write_latch_r <= 1'b0;
      end else if (phase_r == snvm_pkg::PH_STATUS_WRITE || phase_r == snvm_pkg::PH_MEM_WRITE) begin
        write_latch_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // protection bits
  // ----------------------------------------------------------------
  // rst stands in for the first power-up of a blank part
  always_ff @(posedge sck or posedge rst_link_r) begin
    if (rst_link_r) begin
      pin_protect_enable_r <= 1'b0;
      block_protect_r <= snvm_pkg::BP_NONE;
    end else if (status_we) begin
      pin_protect_enable_r <= status_in.pin_protect_enable;
      block_protect_r <= {status_in.block_protect_hi, status_in.block_protect_lo};
    end
  end

  // ----------------------------------------------------------------
  // array, no reset so content survives rst
  // ----------------------------------------------------------------
  always_ff @(posedge sck) begin
    if (mem_we) begin
      mem_r[addr_r] <= rx_byte;
    end
  end

  always_ff @(posedge sck or posedge rst_link_r) begin
    if (rst_link_r) begin
      commit_tog_r <= 1'b0;
    end else if (mem_we) begin
      commit_tog_r <= ~commit_tog_r;
    end
  end

  // ----------------------------------------------------------------
  // crossing to the system clock
  // ----------------------------------------------------------------
  // all single-bit levels; the commit event travels as a toggle
  logic [3:0] sync_a_r;
  logic [3:0] sync_b_r;
  logic commit_seen_r;
  logic [3:0] sync_src;

  assign sync_src = {commit_tog_r, mode3_r, write_latch_r, ~cs_n};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a_r <= 4'h0;
      sync_b_r <= 4'h0;
    end else begin
      sync_a_r <= sync_src;
      sync_b_r <= sync_a_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      commit_seen_r <= 1'b0;
      sys_commit_pulse <= 1'b0;
    end else begin
      commit_seen_r <= sync_b_r[3];
      sys_commit_pulse <= sync_b_r[3] ^ commit_seen_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_selected <= 1'b0;
      sys_write_latch <= 1'b0;
      sys_mode3 <= 1'b0;
    end else begin
      sys_selected <= sync_b_r[0];
      sys_write_latch <= sync_b_r[1];
      sys_mode3 <= sync_b_r[2];
    end
  end

endmodule

// ===== sim/snvm_chk_checker.sv
// pin-level assertions for the serial memory slave
`timescale 1ns/10ps
module snvm_chk (
  // system side
  input wire logic clk,
  input wire logic rst,
  // spi pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so_o,
  input wire logic so_oe,
  // observation
  input wire logic sys_selected,
  input wire logic sys_write_latch,
  input wire logic sys_mode3,
  input wire logic sys_commit_pulse
);
  // ----------------------------------------------------------------
  // per-selection edge count and op-code capture
  // ----------------------------------------------------------------
  logic [15:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] op_r;
  logic rd_op;
  assign rd_op = (op_r == snvm_pkg::OP_STATUS_READ) || (op_r == snvm_pkg::OP_MEM_READ);
  // saturates so a very long burst cannot wrap back into the op-code window
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      cnt_r <= 16'h0000;
    end else if (hold_n && cnt_r != 16'hffff) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge sck) begin
    if (!cs_n && hold_n) begin
      sh_r <= {sh_r[6:0], si};
    end
  end
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      op_r <= 8'hff;
    end else if (hold_n && cnt_r == 16'h0007) begin
      op_r <= {sh_r[6:0], si};
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  oe_desel_a: assert property (@(posedge clk) disable iff (rst) cs_n |-> !so_oe)
    else $error("so driven while deselected");
  oe_hold_a: assert property (@(posedge clk) disable iff (rst) !hold_n |-> !so_oe)
    else $error("so driven during hold");
  sel_on_a: assert property (@(posedge clk) disable iff (rst) (!cs_n) [*5] |-> sys_selected)
    else $error("selection not reported");
  sel_off_a: assert property (@(posedge clk) disable iff (rst) cs_n [*5] |-> !sys_selected)
    else $error("standby not reported");
  pulse_one_a: assert property (@(posedge clk) disable iff (rst)
    sys_commit_pulse |=> !sys_commit_pulse)
    else $error("commit pulse too long");
  st_on_a: assert property (@(posedge sck) disable iff (rst || cs_n)
    (cnt_r == 16'h0008 && op_r == snvm_pkg::OP_STATUS_READ && hold_n) |-> so_oe)
    else $error("status byte not driven");
  st_off_a: assert property (@(posedge sck) disable iff (rst || cs_n)
    (cnt_r >= 16'h0010 && op_r == snvm_pkg::OP_STATUS_READ) |-> !so_oe)
    else $error("status read longer than one byte");
  rd_on_a: assert property (@(posedge sck) disable iff (rst || cs_n)
    (cnt_r >= 16'h0018 && op_r == snvm_pkg::OP_MEM_READ && hold_n) |-> so_oe)
    else $error("read data not driven");
  quiet_a: assert property (@(posedge sck) disable iff (rst || cs_n)
    (cnt_r < 16'h0008 || !rd_op) |-> !so_oe)
    else $error("so driven outside read data");
endmodule

bind snvm_core snvm_chk chk (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
  .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe), .sys_selected(sys_selected),
  .sys_write_latch(sys_write_latch), .sys_mode3(sys_mode3),
  .sys_commit_pulse(sys_commit_pulse));

// ===== sim/snvm_host.sv
// host spi master model for the serial memory slave
`timescale 1ns/10ps
module snvm_host (
  // spi pins
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  input wire logic so_o,
  input wire logic so_oe
);
  logic m3_r;
  // no pull on so: a released line shows the inverse of its last value
  wire so_w = so_oe ? so_o : ~so_o;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    m3_r = 1'b0;
  end
  // clock runs only inside these tasks and stands still otherwise
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      #32 sck = 1'b1;
      #32 sck = 1'b0;
    end
  endtask
  task automatic start(input logic m3);
    m3_r = m3;
    sck = m3;
    #13 cs_n = 1'b0;
    #32 sck = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      #32 sck = 1'b1;
      rx[i] = so_w;
      #32 sck = 1'b0;
    end
  endtask
  task automatic stop();
    #32 cs_n = 1'b1;
    #13 sck = m3_r;
    si = ~si;
  endtask
  // sck is low here, so hold moves only in the low phase
  task automatic pause(input int n);
    // step off the falling edge so hold never moves with sck
    #16 hold_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = ~si;
      #32 sck = 1'b1;
      #32 sck = 1'b0;
    end
    #32 hold_n = 1'b1;
  endtask
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the serial memory slave
`timescale 1ns/10ps
module tb_top;
  logic clk;
  logic rst;
  logic wp_n;
  logic sck, cs_n, si, hold_n, so_o, so_oe, sel, wl, m3, cp;
  int num_errors = 0;
  int compares = 0;
  int ncommit = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (cp === 1'b1) ncommit <= ncommit + 1;
  snvm_core dut (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe), .sys_selected(sel), .sys_write_latch(wl),
    .sys_mode3(m3), .sys_commit_pulse(cp));
  snvm_host host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_o(so_o),
    .so_oe(so_oe));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    logic [7:0] rx;
    host.start(1'b0);
    host.xbyte(op, rx);
    host.stop();
  endtask
  task automatic st_rd(input logic md, output logic [7:0] s);
    logic [7:0] rx;
    host.start(md);
    host.xbyte(snvm_pkg::OP_STATUS_READ, rx);
    host.xbyte(8'h5a, s);
    host.stop();
  endtask
  task automatic st_wr(input logic [7:0] v);
    logic [7:0] rx;
    host.start(1'b0);
    host.xbyte(snvm_pkg::OP_STATUS_WRITE, rx);
    host.xbyte(v, rx);
    host.stop();
  endtask
  // up to three data bytes, first in the top byte of d
  task automatic mem(input logic [7:0] op, input logic [15:0] a, input logic [23:0] d,
    input int n, input logic hp, output logic [23:0] q);
    logic [7:0] rx;
    q = 24'h00_0000;
    host.start(1'b0);
    host.xbyte(op, rx);
    host.xbyte(a[15:8], rx);
    host.xbyte(a[7:0], rx);
    for (int i = 0; i < n; i++) begin
      host.xbyte(d[23-8*i -: 8], rx);
      q[23-8*i -: 8] = rx;
      if (hp && i == 0) host.pause(3);
    end
    host.stop();
  endtask
  task automatic wait_wl(input logic e);
    int i;
    for (i = 0; i < 20 && wl !== e; i++) @(posedge clk);
    chk({7'h00, wl}, {7'h00, e});
  endtask
  task automatic print_verdict();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] s;
    logic [7:0] rx;
    st_rd(1'b0, s);
    chk(s, snvm_pkg::STATUS_RESET);
    // a second op-code behind a status read must be ignored
    host.start(1'b0);
    host.xbyte(snvm_pkg::OP_STATUS_READ, rx);
    host.xbyte(8'h00, s);
    host.xbyte(snvm_pkg::OP_SET_WRITE_LATCH, rx);
    host.stop();
    chk(s, snvm_pkg::STATUS_RESET);
    st_rd(1'b0, s);
    chk(s, snvm_pkg::STATUS_RESET);
    $display("test reset status done");
  endtask
  task automatic t_latch();
    logic [7:0] s;
    cmd(snvm_pkg::OP_SET_WRITE_LATCH);
    wait_wl(1'b1);
    st_rd(1'b1, s);
    chk(s, 8'h02);
    chk({7'h00, m3}, 8'h01);
    cmd(snvm_pkg::OP_CLEAR_WRITE_LATCH);
    wait_wl(1'b0);
    st_rd(1'b0, s);
    chk(s, 8'h00);
    chk({7'h00, m3}, 8'h00);
    $display("test latch set clear done");
  endtask
  task automatic t_burst();
    logic [7:0] s;
    logic [23:0] q;
    int n0;
    cmd(snvm_pkg::OP_SET_WRITE_LATCH);
    n0 = ncommit;
    mem(snvm_pkg::OP_MEM_WRITE, 16'hfffe, 24'ha5_5a3c, 3, 1'b0, q);
    repeat (8) @(posedge clk);
    chk(8'(ncommit - n0), 8'h03);
    st_rd(1'b0, s);
    chk(s, 8'h00);
    // si toggles through the data phase; the device must not care
    mem(snvm_pkg::OP_MEM_READ, 16'h1ffe, 24'hc3_96e1, 3, 1'b1, q);
    chk(q[23:16], 8'ha5);
    chk(q[15:8], 8'h5a);
    chk(q[7:0], 8'h3c);
    $display("test burst wrap hold done");
  endtask
  task automatic t_refused();
    logic [23:0] q;
    mem(snvm_pkg::OP_MEM_WRITE, 16'h0000, 24'h7700_00, 1, 1'b0, q);
    mem(snvm_pkg::OP_MEM_READ, 16'h0000, 24'h0000_00, 1, 1'b0, q);
    chk(q[23:16], 8'h3c);
    $display("test write without latch done");
  endtask
  task automatic t_protect();
    logic [7:0] s;
    logic [23:0] q;
    cmd(snvm_pkg::OP_SET_WRITE_LATCH);
    st_wr(8'hff);
    st_rd(1'b0, s);
    chk(s, 8'h8c);
    @(posedge clk) wp_n <= 1'b0;
    cmd(snvm_pkg::OP_SET_WRITE_LATCH);
    st_wr(8'h04);
    st_rd(1'b0, s);
    chk(s, 8'h8c);
    @(posedge clk) wp_n <= 1'b1;
    cmd(snvm_pkg::OP_SET_WRITE_LATCH);
    st_wr(8'h04);
    st_rd(1'b0, s);
    chk(s, 8'h04);
    cmd(snvm_pkg::OP_SET_WRITE_LATCH);
    mem(snvm_pkg::OP_MEM_WRITE, 16'h1fff, 24'h6677_00, 2, 1'b0, q);
    mem(snvm_pkg::OP_MEM_READ, 16'h1fff, 24'h0000_00, 2, 1'b0, q);
    chk(q[23:16], 8'h5a);
    chk(q[15:8], 8'h77);
    $display("test protection done");
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b0;
    wp_n = 1'b1;
    // a real rising edge on rst, so every async reset flop sees it
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    host.idle(2);
    t_reset();
    t_latch();
    t_burst();
    t_refused();
    t_protect();
    print_verdict();
  end
  initial begin
    #1000000;
    num_errors++;
    print_verdict();
  end
endmodule
